// *** rtl/ucr_defines.svh ***
// ucr_defines.svh - offsets, field positions, masks and reset values of the usb control registers
// Notes on behaviour
// R1 - sixteen endpoint control registers, numbered 0 to 15, sharing one bit layout.
// R2 - host mode, endpoint 0 bit 7: direct low-speed link, else via hub preamble.
// R3 - host mode, endpoint 0 bit 6: clear lets hardware retry NAK'd transactions.
// R4 - bit 4 excludes endpoint from SETUP only when receive and transmit both enabled.
// R5 - bit 3 enables endpoint reception when set.
// R6 - bit 2 enables endpoint transmission when set.
// R7 - bit 1 reads one once the endpoint has been stalled.
// R8 - bit 0 enables handshake packets; clear suits isochronous endpoints.
// R9 - bits 31 to 8 and all unimplemented bits ignore writes, read zero.
// R10 - registers have clear, set, invert aliases at plus 0x4, 0x8, 0xc.
// R11 - otg, main and error interrupt flag registers offer only the clear alias.
// R12 - otg line status and transfer status have no aliases at all.
// R13 - activity pending, endpoint number, j-state and se0 have undefined reset value.
// R14 - alias writes clear, set or toggle bits written one; zeros leave bits.
`ifndef UCR_DEFINES_SVH
`define UCR_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define UCR_OFF_OTG_IF 16'h5040
`define UCR_OFF_OTG_IE 16'h5050
`define UCR_OFF_OTG_STAT 16'h5060
`define UCR_OFF_OTG_CON 16'h5070
`define UCR_OFF_PWRC 16'h5080
`define UCR_OFF_USB_IF 16'h5200
`define UCR_OFF_USB_IE 16'h5210
`define UCR_OFF_ERR_IF 16'h5220
`define UCR_OFF_ERR_IE 16'h5230
`define UCR_OFF_STAT 16'h5240
`define UCR_OFF_CON 16'h5250
`define UCR_OFF_ADDR 16'h5260
`define UCR_OFF_BDTP 16'h5270
`define UCR_EP_PAGE 8'h53

// ---------------------------------------------------------------
// writable bit masks
// ---------------------------------------------------------------
`define UCR_MSK_OTG_IF 8'hfd
`define UCR_MSK_OTG_IE 8'hfd
`define UCR_MSK_OTG_CON 8'hff
`define UCR_MSK_PWRC 8'h13
`define UCR_MSK_USB_IF 8'hff
`define UCR_MSK_USB_IE 8'hff
`define UCR_MSK_ERR_IF 8'hff
`define UCR_MSK_ERR_IE 8'hff
`define UCR_MSK_CON 8'h3f
`define UCR_MSK_ADDR 8'hff
`define UCR_MSK_BDTP 8'hfe
`define UCR_MSK_EP 8'hdf
`define UCR_RST_VAL 8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define UCR_EP_LSD 7
`define UCR_EP_NORETRY 6
`define UCR_EP_NOSETUP 4
`define UCR_EP_RX 3
`define UCR_EP_TX 2
`define UCR_EP_STALL 1
`define UCR_EP_HSHK 0
`define UCR_CON_HOST 3
`define UCR_CON_LINE_J_STATE 7
`define UCR_CON_SE0 6
`define UCR_PWR_ACTPND 7
`define UCR_PWR_BUSY 3
`define UCR_STAT_EP_LSB 4
`define UCR_STAT_DIR 3
`define UCR_STAT_PPBI 2
`define UCR_OTG_ID 7
`define UCR_OTG_LSTATE 5
`define UCR_OTG_SESVD 3
`define UCR_OTG_SESEND 2
`define UCR_OTG_VBUSVD 0

`endif

// *** rtl/ucr_pkg.sv ***
// ucr_pkg.sv - types and the alias write function of the usb control registers
package ucr_pkg;

  typedef enum logic [1:0] {
    UCR_AL_NONE = 2'h0,
    UCR_AL_CLR = 2'h1,
    UCR_AL_SET = 2'h2,
    UCR_AL_INV = 2'h3
  } ucr_alias_t;

  typedef enum logic [1:0] {
    UCR_PH_IDLE = 2'b00,
    UCR_PH_WRITE = 2'b01,
    UCR_PH_READ = 2'b10
  } ucr_phase_t;

  // new value of a byte register after a write through one of its addresses
  function automatic logic [7:0] ucr_apply(input logic [7:0] cur, input logic [7:0] wd,
                                           input ucr_alias_t al, input logic [7:0] msk);
    logic [7:0] nx;
    nx = cur;
    unique case (al)
      UCR_AL_NONE: nx = wd;
      UCR_AL_CLR: nx = cur & ~wd;
      UCR_AL_SET: nx = cur | wd;
      UCR_AL_INV: nx = cur ^ wd;
    endcase
    return (nx & msk) | (cur & ~msk);
  endfunction

endpackage

// *** rtl/ucr_ep_reg.sv ***
// ucr_ep_reg.sv - one endpoint control register
`timescale 1ns/10ps
`default_nettype none
`include "ucr_defines.svh"
module ucr_ep_reg
  import ucr_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic resetn, // sync reset, low
  input wire logic wr_en, // write to this endpoint
  input wire logic [1:0] al_sel, // alias of the write
  input wire logic [7:0] wdata, // write byte
  input wire logic stall_evt, // engine stalled endpoint
  output logic [7:0] ctrl_q // register contents
);

  logic [7:0] wr_val;
  logic [7:0] ctrl_d;

  // R14 alias write action
  assign wr_val = wr_en ? ucr_apply(ctrl_q, wdata, ucr_alias_t'(al_sel), `UCR_MSK_EP) : ctrl_q;
  // R7 stall set wins
  assign ctrl_d = wr_val | ({7'h00, stall_evt} << `UCR_EP_STALL);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl_q <= `UCR_RST_VAL;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

endmodule // ucr_ep_reg
`default_nettype wire

// *** rtl/ucr_regs.sv ***
// ucr_regs.sv - usb controller register set behind an ahb-lite slave
`timescale 1ns/10ps
`default_nettype none
`include "ucr_defines.svh"
module ucr_regs
  import ucr_pkg::*;
#(
  parameter int N_EP = 16,
  parameter int ADDR_W = 16
) (
  input wire logic mclk, // 100 mhz clock
  input wire logic resetn, // sync reset, low
  input wire logic hsel, // slave select
  input wire logic [ADDR_W-1:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic [N_EP-1:0] ep_stall_evt, // engine stall pulses
  input wire logic [7:0] otg_evt, // otg event pulses
  input wire logic [7:0] usb_evt, // main event pulses
  input wire logic [7:0] err_evt, // error event pulses
  input wire logic trn_done, // token done pulse
  input wire logic [3:0] trn_endpoint, // token endpoint
  input wire logic trn_dir, // token direction
  input wire logic trn_ppbi, // ping-pong index
  input wire logic bus_busy, // engine busy level
  input wire logic activity_in, // bus activity level
  input wire logic line_j_pin, // j-state pin
  input wire logic line_se0_pin, // se0 pin
  input wire logic [4:0] otg_comp_pins, // id,lstate,sesvd,sesend,vbusvd
  output logic [N_EP-1:0] ep_rx_en, // endpoint receive enables
  output logic [N_EP-1:0] ep_tx_en, // endpoint transmit enables
  output logic [N_EP-1:0] ep_hshk_en, // handshake enables
  output logic [N_EP-1:0] ep_stalled, // stall status
  output logic [N_EP-1:0] ep_setup_ok, // setup allowed
  output logic low_speed_direct, // host direct low speed
  output logic auto_retry_en, // host hardware retry
  output logic [7:0] otg_ctrl, // otg line control
  output logic [7:0] pwr_ctrl, // power control
  output logic [7:0] usb_ctrl, // module control
  output logic [7:0] func_addr, // function address
  output logic [7:0] bdt_ptr_low, // descriptor page
  output logic [7:0] otg_int_en, // otg interrupt enables
  output logic [7:0] usb_int_en, // main interrupt enables
  output logic [7:0] err_int_en // error interrupt enables
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (N_EP < 1 || N_EP > 16) begin : g_bad_ep
    $error("N_EP must lie in 1..16");
  end
  if (ADDR_W < 16) begin : g_bad_aw
    $error("ADDR_W must be at least 16");
  end

  // ---------------------------------------------------------------
  // register tables
  // ---------------------------------------------------------------
  localparam int N_CFG = 8;
  localparam int N_FLG = 3;
  localparam logic [15:0] CFG_OFF [N_CFG] = '{`UCR_OFF_OTG_IE, `UCR_OFF_OTG_CON, `UCR_OFF_PWRC,
    `UCR_OFF_USB_IE, `UCR_OFF_ERR_IE, `UCR_OFF_CON, `UCR_OFF_ADDR, `UCR_OFF_BDTP};
  localparam logic [7:0] CFG_MSK [N_CFG] = '{`UCR_MSK_OTG_IE, `UCR_MSK_OTG_CON, `UCR_MSK_PWRC,
    `UCR_MSK_USB_IE, `UCR_MSK_ERR_IE, `UCR_MSK_CON, `UCR_MSK_ADDR, `UCR_MSK_BDTP};
  localparam logic [15:0] FLG_OFF [N_FLG] = '{`UCR_OFF_OTG_IF, `UCR_OFF_USB_IF, `UCR_OFF_ERR_IF};
  localparam logic [7:0] FLG_MSK [N_FLG] = '{`UCR_MSK_OTG_IF, `UCR_MSK_USB_IF, `UCR_MSK_ERR_IF};

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  ucr_phase_t phase_q;
  ucr_phase_t phase_d;
  logic [15:0] addr_q;
  logic acc;
  logic wr_now;
  logic rd_now;
  ucr_alias_t al;
  logic [11:0] page;
  logic [7:0] wbyte;
  logic [7:0] rd8;

  assign acc = hsel & htrans[1] & hready;
  assign phase_d = acc ? (hwrite ? UCR_PH_WRITE : UCR_PH_READ) : UCR_PH_IDLE;
  assign wr_now = (phase_q == UCR_PH_WRITE);
  assign rd_now = (phase_q == UCR_PH_READ);
  assign al = ucr_alias_t'(addr_q[3:2]);
  assign page = addr_q[15:4];
  assign wbyte = hwdata[7:0];

  // reads take one wait state because hrdata is registered from rd8 in the first data-phase cycle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      phase_q <= UCR_PH_IDLE;
      addr_q <= 16'h0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      phase_q <= phase_d;
      if (acc) begin
        addr_q <= haddr[15:0];
      end
      hreadyout <= !(acc & !hwrite);
      hresp <= 1'b0;
      if (rd_now) begin
        // R9 upper bits zero
        hrdata <= {24'h000000, rd8};
      end
    end
  end

  // ---------------------------------------------------------------
  // plain control registers
  // ---------------------------------------------------------------
  logic [7:0] cfg_q [N_CFG];
  logic [7:0] cfg_rd [N_CFG];

  for (genvar i = 0; i < N_CFG; i++) begin : g_cfg
    logic hit;
    logic [7:0] cfg_d;
    assign hit = (page == CFG_OFF[i][15:4]);
    // R10 R14 alias updates
    assign cfg_d = (wr_now && hit) ? ucr_apply(cfg_q[i], wbyte, al, CFG_MSK[i]) : cfg_q[i];
    assign cfg_rd[i] = (hit && al == UCR_AL_NONE) ? cfg_q[i] : 8'h00;
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        cfg_q[i] <= `UCR_RST_VAL;
      end else begin
        cfg_q[i] <= cfg_d;
      end
    end
  end

  assign otg_int_en = cfg_q[0];
  assign otg_ctrl = cfg_q[1];
  assign pwr_ctrl = cfg_q[2];
  assign usb_int_en = cfg_q[3];
  assign err_int_en = cfg_q[4];
  assign usb_ctrl = cfg_q[5];
  assign func_addr = cfg_q[6];
  assign bdt_ptr_low = cfg_q[7];

  // ---------------------------------------------------------------
  // sticky event flags
  // ---------------------------------------------------------------
  logic [7:0] flg_q [N_FLG];
  logic [7:0] flg_rd [N_FLG];
  logic [7:0] flg_evt [N_FLG];

  assign flg_evt[0] = otg_evt;
  assign flg_evt[1] = usb_evt;
  assign flg_evt[2] = err_evt;

  for (genvar i = 0; i < N_FLG; i++) begin : g_flg
    logic hit;
    logic clr_wr;
    logic [7:0] flg_d;
    assign hit = (page == FLG_OFF[i][15:4]);
    // R11 only base and clear alias act
    assign clr_wr = wr_now && hit && (al == UCR_AL_NONE || al == UCR_AL_CLR);
    // an event in the clearing cycle is kept
    assign flg_d = ((clr_wr ? (flg_q[i] & ~wbyte) : flg_q[i]) | flg_evt[i]) & FLG_MSK[i];
    assign flg_rd[i] = (hit && al == UCR_AL_NONE) ? flg_q[i] : 8'h00;
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        flg_q[i] <= `UCR_RST_VAL;
      end else begin
        flg_q[i] <= flg_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // endpoint control registers
  // ---------------------------------------------------------------
  logic [7:0] ep_q [N_EP];
  logic [7:0] ep_rd [N_EP];
  logic ep_page;

  assign ep_page = (addr_q[15:8] == `UCR_EP_PAGE);

  // R1 one register per endpoint
  for (genvar i = 0; i < N_EP; i++) begin : g_ep
    logic hit;
    assign hit = ep_page && (addr_q[7:4] == 4'(i));
    ucr_ep_reg u_ep (
      .mclk(mclk),
      .resetn(resetn),
      .wr_en(wr_now && hit),
      .al_sel(addr_q[3:2]),
      .wdata(wbyte),
      .stall_evt(ep_stall_evt[i]),
      .ctrl_q(ep_q[i])
    );
    assign ep_rd[i] = (hit && al == UCR_AL_NONE) ? ep_q[i] : 8'h00;
    // R5 receive enable
    assign ep_rx_en[i] = ep_q[i][`UCR_EP_RX];
    // R6 transmit enable
    assign ep_tx_en[i] = ep_q[i][`UCR_EP_TX];
    // R8 handshake enable
    assign ep_hshk_en[i] = ep_q[i][`UCR_EP_HSHK];
    // R7 stall status
    assign ep_stalled[i] = ep_q[i][`UCR_EP_STALL];
    // R4 setup eligibility
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        ep_setup_ok[i] <= 1'b0;
      end else begin
        ep_setup_ok[i] <= ep_q[i][`UCR_EP_RX] & ep_q[i][`UCR_EP_TX] & ~ep_q[i][`UCR_EP_NOSETUP];
      end
    end
  end

  // ---------------------------------------------------------------
  // host-mode controls from endpoint 0
  // ---------------------------------------------------------------
  logic host_mode;
  assign host_mode = usb_ctrl[`UCR_CON_HOST];

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      low_speed_direct <= 1'b0;
      auto_retry_en <= 1'b0;
    end else begin
      // R2 direct low speed
      low_speed_direct <= host_mode & ep_q[0][`UCR_EP_LSD];
      // R3 hardware retry
      auto_retry_en <= host_mode & ~ep_q[0][`UCR_EP_NORETRY];
    end
  end

  // ---------------------------------------------------------------
  // line and transfer status
  // ---------------------------------------------------------------
  logic [1:0] j_sync_q;
  logic [1:0] se0_sync_q;
  logic act_q;
  logic [3:0] stat_ep_q;
  logic [4:0] otg_s1_q;
  logic [4:0] otg_s2_q;
  logic stat_dir_q;
  logic stat_ppbi_q;

  // R13 no reset on these
  always_ff @(posedge mclk) begin
    j_sync_q <= {j_sync_q[0], line_j_pin};
    se0_sync_q <= {se0_sync_q[0], line_se0_pin};
    act_q <= activity_in;
    if (trn_done) begin
      stat_ep_q <= trn_endpoint;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      otg_s1_q <= 5'h00;
      otg_s2_q <= 5'h00;
      stat_dir_q <= 1'b0;
      stat_ppbi_q <= 1'b0;
    end else begin
      otg_s1_q <= otg_comp_pins;
      otg_s2_q <= otg_s1_q;
      if (trn_done) begin
        stat_dir_q <= trn_dir;
        stat_ppbi_q <= trn_ppbi;
      end
    end
  end

  // R12 status words answer only at their base
  logic otg_stat_hit;
  logic stat_hit;
  logic pwr_hit;
  logic con_hit;
  logic [7:0] otg_stat_rd;
  logic [7:0] stat_rd;
  logic [7:0] live_rd;

  assign otg_stat_hit = (page == `UCR_OFF_OTG_STAT >> 4) && (al == UCR_AL_NONE);
  assign stat_hit = (page == `UCR_OFF_STAT >> 4) && (al == UCR_AL_NONE);
  assign pwr_hit = (page == `UCR_OFF_PWRC >> 4) && (al == UCR_AL_NONE);
  assign con_hit = (page == `UCR_OFF_CON >> 4) && (al == UCR_AL_NONE);
  assign otg_stat_rd = otg_stat_hit ? {otg_s2_q[4], 1'b0, otg_s2_q[3], 1'b0, otg_s2_q[2],
                                       otg_s2_q[1], 1'b0, otg_s2_q[0]} : 8'h00;
  assign stat_rd = stat_hit ? {stat_ep_q, stat_dir_q, stat_ppbi_q, 2'b00} : 8'h00;
  assign live_rd = (pwr_hit ? (({7'h00, act_q} << `UCR_PWR_ACTPND) | ({7'h00, bus_busy} << `UCR_PWR_BUSY))
                            : 8'h00)
                 | (con_hit ? (({7'h00, j_sync_q[1]} << `UCR_CON_LINE_J_STATE)
                             | ({7'h00, se0_sync_q[1]} << `UCR_CON_SE0)) : 8'h00);

  // R9 unmapped reads zero
  always_comb begin
    rd8 = otg_stat_rd | stat_rd | live_rd;
    for (int k = 0; k < N_CFG; k++) begin
      rd8 = rd8 | cfg_rd[k];
    end
    for (int k = 0; k < N_FLG; k++) begin
      rd8 = rd8 | flg_rd[k];
    end
    for (int k = 0; k < N_EP; k++) begin
      rd8 = rd8 | ep_rd[k];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic ep0_wr;
  logic con_set_wr;
  logic usb_if_bad_wr;
  assign ep0_wr = wr_now && ep_page && addr_q[7:4] == 4'h0 && al == UCR_AL_NONE;
  assign con_set_wr = wr_now && page == (`UCR_OFF_OTG_CON >> 4) && al == UCR_AL_SET;
  assign usb_if_bad_wr = wr_now && page == (`UCR_OFF_USB_IF >> 4) && (al == UCR_AL_SET || al == UCR_AL_INV);

  property p_ep_rx;
    @(posedge mclk) disable iff (!resetn) ep0_wr |=> ep_rx_en[0] == $past(hwdata[3]);
  endproperty
  a_ep_rx: assert property (p_ep_rx) else $error("receive enable not stored"); // R5
  property p_ep_tx;
    @(posedge mclk) disable iff (!resetn) ep0_wr |=> ep_tx_en[0] == $past(hwdata[2]);
  endproperty
  a_ep_tx: assert property (p_ep_tx) else $error("transmit enable not stored"); // R6
  property p_ep_hshk;
    @(posedge mclk) disable iff (!resetn) ep0_wr |=> ep_hshk_en[0] == $past(hwdata[0]);
  endproperty
  a_ep_hshk: assert property (p_ep_hshk) else $error("handshake enable not stored"); // R8
  property p_ep_stall;
    @(posedge mclk) disable iff (!resetn) ep_stall_evt[0] |=> ep_stalled[0];
  endproperty
  a_ep_stall: assert property (p_ep_stall) else $error("stall event lost"); // R7
  property p_setup;
    @(posedge mclk) disable iff (!resetn)
      ##1 ep_setup_ok[0] == $past(ep_rx_en[0] & ep_tx_en[0] & ~ep_q[0][`UCR_EP_NOSETUP]);
  endproperty
  a_setup: assert property (p_setup) else $error("setup eligibility wrong"); // R4
  property p_lsd;
    @(posedge mclk) disable iff (!resetn) ##1 low_speed_direct == $past(host_mode & ep_q[0][7]);
  endproperty
  a_lsd: assert property (p_lsd) else $error("low speed direct wrong"); // R2
  property p_retry;
    @(posedge mclk) disable iff (!resetn) ##1 auto_retry_en == $past(host_mode & ~ep_q[0][6]);
  endproperty
  a_retry: assert property (p_retry) else $error("retry enable wrong"); // R3
  property p_upper_zero;
    @(posedge mclk) disable iff (!resetn) hreadyout |-> hrdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set"); // R9
  property p_set_alias;
    @(posedge mclk) disable iff (!resetn) con_set_wr |=> otg_ctrl == ($past(otg_ctrl) | $past(hwdata[7:0]));
  endproperty
  a_set_alias: assert property (p_set_alias) else $error("set alias failed"); // R14
  property p_flag_no_set;
    @(posedge mclk) disable iff (!resetn) usb_if_bad_wr && usb_evt == 8'h00 |=> $stable(flg_q[1]);
  endproperty
  a_flag_no_set: assert property (p_flag_no_set) else $error("flag set alias acted"); // R11
  property p_read_wait;
    @(posedge mclk) disable iff (!resetn) acc && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong"); // one read wait state

  property p_cov_stall_clear;
    @(posedge mclk) disable iff (!resetn) ep_stalled[0] ##1 !ep_stalled[0];
  endproperty
  c_stall_clear: cover property (p_cov_stall_clear);
  property p_cov_host_lsd;
    @(posedge mclk) disable iff (!resetn) low_speed_direct && !auto_retry_en;
  endproperty
  c_host_lsd: cover property (p_cov_host_lsd);
  property p_cov_setup;
    @(posedge mclk) disable iff (!resetn) ep_setup_ok[0] ##1 !ep_setup_ok[0];
  endproperty
  c_setup: cover property (p_cov_setup);

endmodule // ucr_regs
`default_nettype wire

// *** tb/ucr_usb_model.sv ***
// ucr_usb_model.sv - behavioural usb engine side driving event pulses
`timescale 1ns/10ps
`default_nettype none
module ucr_usb_model (
  input wire logic mclk, // clock
  input wire logic resetn, // sync reset, low
  input wire logic [1:0] cmd, // 1 stall, 2 event, 3 token done
  input wire logic [7:0] arg, // endpoint, event bits or token fields
  output logic [15:0] ep_stall_evt, // stall pulses
  output logic [7:0] usb_evt, // event pulses
  output logic trn_done, // token done pulse
  output logic [3:0] trn_endpoint, // token endpoint
  output logic trn_dir, // token direction
  output logic trn_ppbi // ping-pong index
);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ep_stall_evt <= 16'h0000;
      usb_evt <= 8'h00;
      trn_done <= 1'b0;
      {trn_endpoint, trn_dir, trn_ppbi} <= 6'h00;
    end else begin
      ep_stall_evt <= (cmd == 2'h1) ? (16'h0001 << arg[3:0]) : 16'h0000;
      usb_evt <= (cmd == 2'h2) ? arg : 8'h00;
      trn_done <= (cmd == 2'h3);
      // token fields are not held past the pulse: flip them so stale values show
      if (cmd == 2'h3) {trn_endpoint, trn_dir, trn_ppbi} <= arg[7:2];
      else if (trn_done) {trn_endpoint, trn_dir, trn_ppbi} <= ~{trn_endpoint, trn_dir, trn_ppbi};
    end
  end
endmodule // ucr_usb_model
`default_nettype wire

// *** tb/tb_usb_endpoint_control_regs.sv ***
// tb_usb_endpoint_control_regs.sv - self-checking bench of the usb control registers
`timescale 1ns/10ps
`default_nettype none
`include "ucr_defines.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_usb_endpoint_control_regs;
  logic mclk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [15:0] haddr = 16'h0000;
  logic [1:0] htrans = 2'h0, cmd = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, r;
  logic [7:0] arg = 8'h00, usb_evt, otg_int_en, otg_ctrl, otg_evt = 8'h00, err_evt = 8'h00;
  logic [15:0] ep_stall_evt, ep_rx_en, ep_tx_en, ep_hshk_en, ep_stalled, ep_setup_ok;
  logic [4:0] otg_comp_pins = 5'h00;
  logic activity_in = 1'b0, line_j_pin = 1'b0, line_se0_pin = 1'b0;
  logic bus_busy = 1'b0, hreadyout, hresp, trn_done, trn_dir, trn_ppbi, low_speed_direct, auto_retry_en;
  logic [3:0] trn_endpoint;
  int num_errors = 0, compares = 0;
  always #5 mclk = ~mclk;
  assign hready = hreadyout;
  ucr_regs #(.N_EP(16), .ADDR_W(16)) dut (.mclk, .resetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata, .ep_stall_evt, .otg_evt,
    .usb_evt, .err_evt, .trn_done, .trn_endpoint, .trn_dir, .trn_ppbi, .bus_busy,
    .activity_in, .line_j_pin, .line_se0_pin, .otg_comp_pins, .ep_rx_en,
    .ep_tx_en, .ep_hshk_en, .ep_stalled, .ep_setup_ok, .low_speed_direct, .auto_retry_en,
    .otg_ctrl, .pwr_ctrl(), .usb_ctrl(), .func_addr(), .bdt_ptr_low(), .otg_int_en,
    .usb_int_en(), .err_int_en());
  ucr_usb_model model (.mclk, .resetn, .cmd, .arg, .ep_stall_evt, .usb_evt, .trn_done,
    .trn_endpoint, .trn_dir, .trn_ppbi);
  // ---------------------------------------------------------------
  // bus and helper tasks
  // ---------------------------------------------------------------
  task automatic bus(input logic [15:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    `CHK("read", e, r)
  endtask
  function automatic logic [15:0] ep(input int n);
    return 16'h5300 + 16'(n * 16);
  endfunction
  // one engine event, then let flags land
  task automatic evt(input logic [1:0] k, input logic [7:0] v);
    cmd <= k; arg <= v;
    @(posedge mclk);
    cmd <= 2'h0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 16; i++) rd_chk(ep(i), 32'h0);
    rd_chk(`UCR_OFF_USB_IF, 32'h0);
    bus(`UCR_OFF_CON, 1'b0, 32'h0);
    `CHK("con", 32'h0, r & 32'hffffff3f)
    rd_chk(16'h6000, 32'h0); // unmapped
  endtask
  task automatic t_ep_bits;
    for (int i = 0; i < 16; i++) bus(ep(i), 1'b1, 32'hffffffff);
    for (int i = 0; i < 16; i++) rd_chk(ep(i), 32'h000000df);
    repeat (2) @(posedge mclk);
    `CHK("rx", 16'hffff, ep_rx_en)
    `CHK("tx", 16'hffff, ep_tx_en)
    `CHK("hshk", 16'hffff, ep_hshk_en)
    `CHK("setup", 16'h0000, ep_setup_ok)
    `CHK("lsd", 1'b0, low_speed_direct)
    bus(ep(3) + 16'h4, 1'b1, 32'h10);
    repeat (2) @(posedge mclk);
    `CHK("setup", 16'h0008, ep_setup_ok)
    bus(ep(3) + 16'h4, 1'b1, 32'h08);
    repeat (2) @(posedge mclk);
    `CHK("setup", 16'h0000, ep_setup_ok)
    `CHK("rx", 16'hfff7, ep_rx_en)
    bus(ep(3) + 16'h8, 1'b1, 32'h08);
    bus(ep(3) + 16'hc, 1'b1, 32'h05);
    rd_chk(ep(3), 32'h000000ca);
    rd_chk(ep(3) + 16'h8, 32'h0);
    repeat (1) @(posedge mclk);
    `CHK("tx", 16'hfff7, ep_tx_en)
    `CHK("hshk", 16'hfff7, ep_hshk_en)
    for (int i = 0; i < 16; i++) bus(ep(i), 1'b1, 32'h0);
  endtask
  task automatic t_host;
    bus(`UCR_OFF_CON, 1'b1, 32'h08);
    repeat (2) @(posedge mclk);
    `CHK("retry", 1'b1, auto_retry_en)
    bus(ep(0) + 16'h8, 1'b1, 32'hc0);
    repeat (2) @(posedge mclk);
    `CHK("lsd", 1'b1, low_speed_direct)
    `CHK("retry", 1'b0, auto_retry_en)
    // device mode must mask both host controls
    bus(`UCR_OFF_CON, 1'b1, 32'h0);
    repeat (2) @(posedge mclk);
    `CHK("lsd", 1'b0, low_speed_direct)
    `CHK("retry", 1'b0, auto_retry_en)
    bus(`UCR_OFF_CON, 1'b1, 32'h08);
    bus(ep(1), 1'b1, 32'h80);
    bus(ep(0) + 16'h4, 1'b1, 32'h80);
    repeat (2) @(posedge mclk);
    `CHK("lsd", 1'b0, low_speed_direct)
    bus(`UCR_OFF_CON, 1'b1, 32'h0);
  endtask
  task automatic t_stall;
    evt(2'h1, 8'h05);
    evt(2'h1, 8'h00);
    rd_chk(ep(5), 32'h02);
    `CHK("stalled", 16'h0021, ep_stalled)
    bus(ep(5) + 16'h4, 1'b1, 32'h02);
    bus(ep(0) + 16'h4, 1'b1, 32'h02);
    rd_chk(ep(5), 32'h0);
    rd_chk(ep(0), 32'h40);
  endtask
  task automatic t_flags;
    evt(2'h2, 8'h81);
    bus(`UCR_OFF_USB_IF + 16'h8, 1'b1, 32'h7e);
    bus(`UCR_OFF_USB_IF + 16'hc, 1'b1, 32'h81);
    rd_chk(`UCR_OFF_USB_IF, 32'h81);
    bus(`UCR_OFF_USB_IF + 16'h4, 1'b1, 32'h01);
    rd_chk(`UCR_OFF_USB_IF, 32'h80);
    evt(2'h3, 8'ha8);
    bus(`UCR_OFF_STAT, 1'b1, 32'h0);
    bus(`UCR_OFF_STAT + 16'h4, 1'b1, 32'hff);
    rd_chk(`UCR_OFF_STAT, 32'ha8);
    bus(`UCR_OFF_OTG_IE + 16'h8, 1'b1, 32'hffffffff);
    rd_chk(`UCR_OFF_OTG_IE, 32'hfd);
    `CHK("otg_ie", 8'hfd, otg_int_en)
    bus(`UCR_OFF_OTG_CON + 16'h8, 1'b1, 32'h5a);
    rd_chk(`UCR_OFF_OTG_CON, 32'h5a);
    `CHK("otg_con", 8'h5a, otg_ctrl)
    bus(`UCR_OFF_BDTP, 1'b1, 32'hff);
    rd_chk(`UCR_OFF_BDTP, 32'hfe);
    otg_evt <= 8'hff;
    err_evt <= 8'h42;
    @(posedge mclk);
    otg_evt <= 8'h00;
    err_evt <= 8'h00;
    rd_chk(`UCR_OFF_OTG_IF, 32'hfd);
    rd_chk(`UCR_OFF_ERR_IF, 32'h42);
    bus(`UCR_OFF_ERR_IF + 16'h4, 1'b1, 32'h02);
    bus(`UCR_OFF_OTG_IF + 16'hc, 1'b1, 32'hff);
    rd_chk(`UCR_OFF_ERR_IF, 32'h40);
    rd_chk(`UCR_OFF_OTG_IF, 32'hfd);
    otg_comp_pins <= 5'h1f;
    bus_busy <= 1'b1;
    activity_in <= 1'b1;
    line_j_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    bus(`UCR_OFF_OTG_STAT + 16'h8, 1'b1, 32'h0);
    rd_chk(`UCR_OFF_OTG_STAT, 32'had);
    rd_chk(`UCR_OFF_CON, 32'h80);
    bus(`UCR_OFF_PWRC, 1'b0, 32'h0);
    `CHK("busy", 32'h88, r)
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_ep_bits();
    t_host();
    t_stall();
    t_flags();
    print_verdict();
  end
  // run needs well under 2000 cycles
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
endmodule // tb_usb_endpoint_control_regs
`default_nettype wire
